// ===== lst_top.sv
// link self-test control and status registers with lane pattern test
// assumes lane pins loop the outbound pattern back; low_speed_control_bus logic on clk
//
// The register offsets and strobed register access are this design's own decisions.
`default_nettype none

module lst_top #(
  parameter int MS_CYC = lst_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rd_data,
  // mirror array lanes, index is channel*8+lane
  output logic      [31:0] lane_tx_data,
  input  wire logic [31:0] lane_rx_pins,
  // low-speed control bus test
  input  wire logic        ls_test_start,
  input  wire logic        ls_test_done,
  input  wire logic [23:0] ls_checksum,
  input  wire logic        ls_packet_error,
  input  wire logic        ls_parity_error,
  // attached array and receiver
  input  wire logic        array_unsupported,
  output logic             serial_rx_reset,
  output logic             irq
);
  localparam int NL    = lst_pkg::NUM_CH * lst_pkg::NUM_LANE;
  localparam int PRE_W = $clog2(MS_CYC + 1);

  lst_pkg::lst_state_e state_reg;
  logic [31:0]        ctrl_reg;
  logic [NL-1:0]      mask_reg;
  logic [NL-1:0]      result_reg;
  logic [NL-1:0]      lane_err;
  logic [NL-1:0]      rx_sync;
  logic [15:0]        limit_reg;
  logic [15:0]        ms_reg;
  logic [PRE_W-1:0]   pre_reg;
  logic [6:0]         lfsr_reg;
  logic               ls_pass_reg;
  logic               ls_pkt_reg;
  logic               ls_par_reg;
  logic [23:0]        ls_sum_reg;
  logic               array_reg;
  logic [lst_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [lst_pkg::IRQ_W-1:0] irq_en_reg;
  logic [lst_pkg::IRQ_W-1:0] irq_set;
  logic               start_req;
  logic               rxrst_hit;
  logic               phase_reg;
  logic               test_end;
  logic [NL-1:0]      mask_next;
  logic [15:0]        dur;
  logic               prbs_bit;

  // strobe decodes
  assign start_req = wr_en && addr == lst_pkg::OFS_START && wr_data[0];
  assign rxrst_hit = wr_en && addr == lst_pkg::OFS_RXRST && wr_data[0];
  assign test_end  = state_reg == lst_pkg::LST_LATCH;
  assign dur       = ctrl_reg[lst_pkg::DUR_LSB +: lst_pkg::DUR_W];
  assign prbs_bit  = lfsr_reg[6] ^ lfsr_reg[5];

  // lane mask: channel bit and lane bit must both be set
  always_comb begin
    mask_next = '0;
    for (int c = 0; c < lst_pkg::NUM_CH; c++) begin
      for (int l = 0; l < lst_pkg::NUM_LANE; l++) begin
        mask_next[c*lst_pkg::NUM_LANE+l] = ctrl_reg[lst_pkg::CHSEL_LSB+c]
                                         & ctrl_reg[lst_pkg::LANE_LSB+l];
      end
    end
  end

  // control register; unused top bits are dropped on write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= lst_pkg::CTRL_RESET;
    end else if (wr_en && addr == lst_pkg::OFS_CTRL) begin
      ctrl_reg <= wr_data & lst_pkg::CTRL_MASK;
    end
  end

  // sequencer; a start while running is ignored to keep results coherent
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= lst_pkg::LST_IDLE;
    end else begin
      unique case (state_reg)
        lst_pkg::LST_IDLE: begin
          if (start_req) begin
            state_reg <= lst_pkg::LST_RUN;
          end
        end
        lst_pkg::LST_RUN: begin
          if (pre_reg == PRE_W'(MS_CYC - 1) && ms_reg == limit_reg - 16'h0001) begin
            state_reg <= lst_pkg::LST_LATCH;
          end
        end
        lst_pkg::LST_LATCH: begin
          state_reg <= lst_pkg::LST_IDLE;
        end
        default: begin
          state_reg <= lst_pkg::LST_IDLE;
        end
      endcase
    end
  end

  // duration and mask captured at start so later writes cannot skew a run
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      limit_reg <= lst_pkg::DEFAULT_MS;
      mask_reg  <= '0;
    end else if (state_reg == lst_pkg::LST_IDLE && start_req) begin
      limit_reg <= (dur == 16'h0000) ? lst_pkg::DEFAULT_MS : dur;
      mask_reg  <= mask_next;
    end
  end

  // millisecond prescaler and millisecond count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_reg <= '0;
      ms_reg  <= '0;
    end else if (state_reg != lst_pkg::LST_RUN) begin
      pre_reg <= '0;
      ms_reg  <= '0;
    end else if (pre_reg == PRE_W'(MS_CYC - 1)) begin
      pre_reg <= '0;
      ms_reg  <= ms_reg + 16'h0001;
    end else begin
      pre_reg <= pre_reg + PRE_W'(1);
    end
  end

  // bit phase: each pattern bit is held two cycles because the pin filter
  // drops any level that lasts one cycle; the lane rate halves in exchange
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end

  // pattern source; lanes outside the mask stay low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lfsr_reg     <= lst_pkg::PRBS_SEED;
      lane_tx_data <= '0;
    end else begin
      if (phase_reg) begin
        lfsr_reg <= {lfsr_reg[5:0], prbs_bit};
      end
      lane_tx_data <= (state_reg == lst_pkg::LST_RUN) ? ({NL{prbs_bit}} & mask_reg)
                                                      : '0;
    end
  end

  // loopback pins enter through the synchroniser
  lst_pin_sync #(.W(NL)) u_rx_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .pin_in  (lane_rx_pins),
    .q       (rx_sync)
  );

  // one checker per lane, cleared at start
  for (genvar i = 0; i < NL; i++) begin : g_chk
    lst_prbs_check u_chk (
      .clk       (clk),
      .reset_n   (reset_n),
      .clear     (state_reg == lst_pkg::LST_IDLE && start_req),
      .enable    (state_reg == lst_pkg::LST_RUN && mask_reg[i] && phase_reg),
      .rx_bit    (rx_sync[i]),
      .error_reg (lane_err[i])
    );
  end

  // results land only when the run ends; untested lanes read as not passed
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_reg <= '0;
    end else if (test_end) begin
      result_reg <= mask_reg & ~lane_err;
    end
  end

  // low-speed bus results; errors stick until the next ls test starts
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ls_pass_reg <= 1'b0;
      ls_pkt_reg  <= 1'b0;
      ls_par_reg  <= 1'b0;
      ls_sum_reg  <= '0;
    end else begin
      if (ls_test_done) begin
        ls_sum_reg  <= ls_checksum;
        ls_pass_reg <= ls_checksum == lst_pkg::LS_GOOD_SUM;
      end
      // an error in the start cycle wins over the clear
      if (ls_packet_error) begin
        ls_pkt_reg <= 1'b1;
      end else if (ls_test_start) begin
        ls_pkt_reg <= 1'b0;
      end
      if (ls_parity_error) begin
        ls_par_reg <= 1'b1;
      end else if (ls_test_start) begin
        ls_par_reg <= 1'b0;
      end
    end
  end

  // attached array check and receiver reset pulse
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      array_reg       <= 1'b0;
      serial_rx_reset <= 1'b0;
    end else begin
      array_reg       <= array_unsupported;
      serial_rx_reset <= rxrst_hit;
    end
  end

  // interrupt events
  assign irq_set[lst_pkg::IRQ_LANE_DONE] = test_end;
  assign irq_set[lst_pkg::IRQ_LS_DONE]   = ls_test_done;
  assign irq_set[lst_pkg::IRQ_LS_ERR]    = ls_packet_error | ls_parity_error;
  assign irq_set[lst_pkg::IRQ_ARRAY]     = array_unsupported & ~array_reg;

  // sticky status, set beats a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_reg <= '0;
      irq_en_reg   <= '0;
      irq          <= 1'b0;
    end else begin
      if (wr_en && addr == lst_pkg::OFS_IRQ_CLR) begin
        irq_stat_reg <= (irq_stat_reg & ~wr_data[lst_pkg::IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      if (wr_en && addr == lst_pkg::OFS_IRQ_EN) begin
        irq_en_reg <= wr_data[lst_pkg::IRQ_W-1:0];
      end
      irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // read mux; data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= '0;
    end else if (!rd_en) begin
      rd_data <= '0;
    end else begin
      unique case (addr)
        lst_pkg::OFS_CTRL:     rd_data <= ctrl_reg;
        lst_pkg::OFS_RUN:      rd_data <= {31'h0, state_reg == lst_pkg::LST_RUN};
        lst_pkg::OFS_LSRES:    rd_data <= {ls_sum_reg, 5'h00, ls_par_reg, ls_pkt_reg,
                                           ls_pass_reg};
        lst_pkg::OFS_ATYPE:    rd_data <= {31'h0, array_reg};
        lst_pkg::OFS_RES0:     rd_data <= {24'h0, result_reg[7:0]};
        lst_pkg::OFS_RES0 + 8'h04: rd_data <= {24'h0, result_reg[15:8]};
        lst_pkg::OFS_RES0 + 8'h08: rd_data <= {24'h0, result_reg[23:16]};
        lst_pkg::OFS_RES0 + 8'h0C: rd_data <= {24'h0, result_reg[31:24]};
        lst_pkg::OFS_IRQ_STAT: rd_data <= {28'h0, irq_stat_reg};
        lst_pkg::OFS_IRQ_EN:   rd_data <= {28'h0, irq_en_reg};
        default:               rd_data <= '0;
      endcase
    end
  end

  // checks
  property p_ctrl_wr;
    @(posedge clk) disable iff (!reset_n)
    wr_en && addr == lst_pkg::OFS_CTRL |=> ctrl_reg == ($past(wr_data) & lst_pkg::CTRL_MASK);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

  property p_default_len;
    @(posedge clk) disable iff (!reset_n)
    state_reg == lst_pkg::LST_IDLE && start_req && dur == 16'h0000 |=> limit_reg == 16'h000A;
  endproperty
  a_default_len: assert property (p_default_len) else $error("zero length not 10 ms");

  property p_mask;
    @(posedge clk) disable iff (!reset_n)
    state_reg == lst_pkg::LST_IDLE && start_req |=> mask_reg == $past(mask_next);
  endproperty
  a_mask: assert property (p_mask) else $error("lane mask not captured");

  property p_tx_gate;
    @(posedge clk) disable iff (!reset_n)
    ##1 (lane_tx_data & ~$past(mask_reg)) == '0;
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("unselected lane driven");

  property p_run_read;
    @(posedge clk) disable iff (!reset_n)
    rd_en && addr == lst_pkg::OFS_RUN |=> rd_data == {31'h0, $past(state_reg) == lst_pkg::LST_RUN};
  endproperty
  a_run_read: assert property (p_run_read) else $error("run status wrong");

  property p_ls_pass;
    @(posedge clk) disable iff (!reset_n)
    ls_test_done |=> ls_pass_reg == ($past(ls_checksum) == lst_pkg::LS_GOOD_SUM);
  endproperty
  a_ls_pass: assert property (p_ls_pass) else $error("checksum verdict wrong");

  property p_ls_err;
    @(posedge clk) disable iff (!reset_n)
    ls_packet_error || ls_parity_error |=> (ls_pkt_reg || !$past(ls_packet_error))
                                          && (ls_par_reg || !$past(ls_parity_error));
  endproperty
  a_ls_err: assert property (p_ls_err) else $error("ls error not flagged");

  property p_rx_reset;
    @(posedge clk) disable iff (!reset_n)
    rxrst_hit |=> serial_rx_reset ##1 (!serial_rx_reset || $past(rxrst_hit));
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("receiver reset not one pulse");

  property p_end;
    @(posedge clk) disable iff (!reset_n)
    test_end |=> state_reg == lst_pkg::LST_IDLE
                 && result_reg == ($past(mask_reg) & ~$past(lane_err));
  endproperty
  a_end: assert property (p_end) else $error("results not latched at end");

  property p_unmapped;
    @(posedge clk) disable iff (!reset_n)
    rd_en && addr == 8'hFC |=> rd_data == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");

  c_test_done: cover property (@(posedge clk) disable iff (!reset_n) test_end);
  c_ls_pass:   cover property (@(posedge clk) disable iff (!reset_n) ls_pass_reg);
  c_irq:       cover property (@(posedge clk) disable iff (!reset_n) $rose(irq));
endmodule

`default_nettype wire

// ===== lst_pkg.sv
// constants, register map and state codes for the link self-test block
// assumes a single 40 MHz clock and a plain strobe register port
`default_nettype none

package lst_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_RUN      = 8'h04;
  localparam logic [7:0] OFS_LSRES    = 8'h08;
  localparam logic [7:0] OFS_ATYPE    = 8'h0C;
  localparam logic [7:0] OFS_RXRST    = 8'h10;
  localparam logic [7:0] OFS_START    = 8'h14;
  localparam logic [7:0] OFS_RES0     = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h34;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h38;
  // control register layout
  localparam int          DUR_LSB    = 0;
  localparam int          DUR_W      = 16;
  localparam int          CHSEL_LSB  = 16;
  localparam int          NUM_CH     = 4;
  localparam int          LANE_LSB   = 20;
  localparam int          NUM_LANE   = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0FFF_0000;
  localparam logic [31:0] CTRL_MASK  = 32'h0FFF_FFFF;
  // low-speed bus result layout
  localparam int          LS_PASS_BIT = 0;
  localparam int          LS_PKT_BIT  = 1;
  localparam int          LS_PAR_BIT  = 2;
  localparam int          LS_SUM_LSB  = 8;
  localparam int          LS_SUM_W    = 24;
  localparam logic [23:0] LS_GOOD_SUM = 24'h3C_7A55;
  // interrupt status bits
  localparam int IRQ_W         = 4;
  localparam int IRQ_LANE_DONE = 0;
  localparam int IRQ_LS_DONE   = 1;
  localparam int IRQ_LS_ERR    = 2;
  localparam int IRQ_ARRAY     = 3;
  // timing
  localparam int          CLK_NS     = 25;
  localparam int          MS_NS      = 1000000;
  localparam int          MS_CYCLES  = MS_NS / CLK_NS;
  localparam logic [15:0] DEFAULT_MS = 16'h000A;
  localparam int          WARMUP     = 16;
  localparam logic [6:0]  PRBS_SEED  = 7'h7F;
  // test sequencer states
  typedef enum logic [2:0] {
    LST_IDLE  = 3'b001,
    LST_RUN   = 3'b010,
    LST_LATCH = 3'b100
  } lst_state_e;
endpackage

`default_nettype wire

// ===== lst_pin_sync.sv
// three-flop input synchroniser with agreement filter
// assumes inputs come from pins outside the clk domain
`default_nettype none

module lst_pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // pins and filtered result
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] agree;

  // s1 feeds only s2, so metastability never reaches logic
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a bit changes only once stages two and three agree
  assign agree = ~(s2_reg ^ s3_reg);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= (agree & s3_reg) | (~agree & q);
    end
  end
endmodule

`default_nettype wire

// ===== lst_prbs_check.sv
// self-synchronising pattern checker for one lane
// assumes the received bit is already in the clk domain
`default_nettype none

module lst_prbs_check #(
  parameter int WARM = lst_pkg::WARMUP
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // control
  input  wire logic clear,
  input  wire logic enable,
  // data and verdict
  input  wire logic rx_bit,
  output logic      error_reg
);
  logic [6:0] hist_reg;
  logic [4:0] fill_reg;

  // history of the last seven bits; the warm-up hides pipeline fill
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hist_reg  <= '0;
      fill_reg  <= '0;
      error_reg <= 1'b0;
    end else if (clear) begin
      hist_reg  <= '0;
      fill_reg  <= '0;
      error_reg <= 1'b0;
    end else if (enable) begin
      hist_reg <= {hist_reg[5:0], rx_bit};
      if (fill_reg != 5'(WARM)) begin
        fill_reg <= fill_reg + 5'h01;
      end else if (rx_bit != (hist_reg[6] ^ hist_reg[5])) begin
        error_reg <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// ===== lst_array_model.sv
// mirror array lane model: loops outbound lane bits back to the receive pins
// assumes lane_tx_data is registered on clk and fault_mask is set by the bench
`default_nettype none

module lst_array_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // lanes and injected faults
  input  wire logic [31:0] lane_tx_data,
  input  wire logic [31:0] fault_mask,
  output logic      [31:0] lane_rx_pins
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] cable_reg;
  logic [31:0] pins_reg;

  // two-cycle cable delay; a faulty lane comes back inverted so it never locks
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cable_reg <= 32'h0000_0000;
      pins_reg  <= 32'h0000_0000;
    end else begin
      cable_reg <= lane_tx_data ^ fault_mask;
      pins_reg  <= cable_reg;
    end
  end

  assign lane_rx_pins = pins_reg;
endmodule

`default_nettype wire

// ===== link_self_test_status_regs_tb.sv
// self-checking bench for the link self-test registers and lane pattern test
// assumes lst_top with a shortened millisecond and the lane loopback model
`default_nettype none

module link_self_test_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int MSC = 20;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wr_data = 32'h0000_0000;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [31:0] rd_data;
  logic [31:0] lane_tx_data;
  logic [31:0] lane_rx_pins;
  logic        ls_test_start = 1'b0;
  logic        ls_test_done = 1'b0;
  logic [23:0] ls_checksum = 24'h00_0000;
  logic        ls_packet_error = 1'b0;
  logic        ls_parity_error = 1'b0;
  logic        array_unsupported = 1'b0;
  logic        serial_rx_reset;
  logic        irq;
  logic [31:0] fault_mask = 32'h0000_0000;
  logic [31:0] rng = 32'h0000_A8DD;
  logic        rd_pend = 1'b0;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cyc = 0;
  logic [31:0] exp_q[$];
  string       name_q[$];
  int          rx_q[$];

  lst_top #(.MS_CYC(MSC)) u_lst_top (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .lane_tx_data(lane_tx_data),
    .lane_rx_pins(lane_rx_pins), .ls_test_start(ls_test_start), .ls_test_done(ls_test_done),
    .ls_checksum(ls_checksum), .ls_packet_error(ls_packet_error),
    .ls_parity_error(ls_parity_error), .array_unsupported(array_unsupported),
    .serial_rx_reset(serial_rx_reset), .irq(irq));

  lst_array_model u_lst_array_model (
    .clk(clk), .reset_n(reset_n), .lane_tx_data(lane_tx_data),
    .fault_mask(fault_mask), .lane_rx_pins(lane_rx_pins));

  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  // cycle count on the falling edge so drivers read it without a race
  always @(negedge clk) begin
    cyc <= cyc + 1;
  end

  function automatic logic [31:0] xrand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // the note is queued with the strobe; the watcher compares it later
  task automatic rd(string what, logic [7:0] a, logic [31:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    exp_q.push_back(exp);
    name_q.push_back(what);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  task automatic irq_chk(logic exp);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("irq", {31'h0, irq}, {31'h0, exp});
  endtask

  // reads run status just after start, near the end and just past the end
  task automatic run_chk(int len);
    rd("running early", lst_pkg::OFS_RUN, 32'h1);
    repeat (len - 8) @(posedge clk);
    rd("running late", lst_pkg::OFS_RUN, 32'h1);
    repeat (6) @(posedge clk);
    rd("running over", lst_pkg::OFS_RUN, 32'h0);
  endtask

  task automatic endt(string name);
    $display("test %s done", name);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watcher: read data stands only in the cycle after the strobe, else zero
  always @(posedge clk) begin
    rd_pend <= rd_en;
    if (rd_pend) begin
      check(name_q.pop_front(), rd_data, exp_q.pop_front());
    end else if (reset_n) begin
      check("idle read data", rd_data, 32'h0);
    end
    if (serial_rx_reset && rx_q.size() == 0) begin
      check("stray rx reset", 32'h1, 32'h0);
    end else if (serial_rx_reset) begin
      check("rx reset cycle", 32'(cyc), 32'(rx_q.pop_front()));
    end
  end

  // a hang counts as a mismatch
  initial begin
    #(25 * 6000);
    n_mismatch++;
    $display("watchdog expired");
    close_out();
  end

  initial begin
    logic [31:0] v;
    logic [23:0] sum;
    logic        pkt;
    logic        par;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rd("ctrl reset", lst_pkg::OFS_CTRL, lst_pkg::CTRL_RESET);
    rd("run reset", lst_pkg::OFS_RUN, 32'h0);
    rd("ls reset", lst_pkg::OFS_LSRES, 32'h0);
    rd("type reset", lst_pkg::OFS_ATYPE, 32'h0);
    v = xrand();
    wr(lst_pkg::OFS_CTRL, v);
    rd("ctrl rw", lst_pkg::OFS_CTRL, v & lst_pkg::CTRL_MASK);
    wr(lst_pkg::OFS_RUN, 32'hFFFF_FFFF);
    rd("run ro", lst_pkg::OFS_RUN, 32'h0);
    rd("unmapped", 8'hFC, 32'h0);
    wr(lst_pkg::OFS_RXRST, 32'h1);
    rx_q.push_back(cyc + 1);
    wr(lst_pkg::OFS_RXRST, 32'hFFFF_FFFE);
    rd("rx reset wo", lst_pkg::OFS_RXRST, 32'h0);
    endt("registers");
    // channels 0 and 2, lanes 2-5, 2 ms; ch0 lane 3 and unused ch2 lane 1 broken
    fault_mask <= 32'h0002_0008;
    wr(lst_pkg::OFS_IRQ_EN, 32'h1);
    wr(lst_pkg::OFS_CTRL, 32'h03C5_0002);
    wr(lst_pkg::OFS_START, 32'h1);
    run_chk(2 * MSC);
    rd("result ch0", lst_pkg::OFS_RES0, 32'h34);
    rd("result ch1", lst_pkg::OFS_RES0 + 8'h04, 32'h0);
    rd("result ch2", lst_pkg::OFS_RES0 + 8'h08, 32'h3C);
    rd("result ch3", lst_pkg::OFS_RES0 + 8'h0C, 32'h0);
    rd("irq done", lst_pkg::OFS_IRQ_STAT, 32'h1);
    irq_chk(1'b1);
    check("lanes idle", lane_tx_data, 32'h0);
    wr(lst_pkg::OFS_IRQ_CLR, 32'h1);
    rd("irq cleared", lst_pkg::OFS_IRQ_STAT, 32'h0);
    irq_chk(1'b0);
    endt("lane selection");
    // zero duration runs the default length, with the interrupt masked
    fault_mask <= 32'h0000_0000;
    wr(lst_pkg::OFS_IRQ_EN, 32'h0);
    wr(lst_pkg::OFS_CTRL, lst_pkg::CTRL_RESET);
    wr(lst_pkg::OFS_START, 32'h1);
    run_chk(10 * MSC);
    for (int c = 0; c < 4; c++) begin
      rd("result all", lst_pkg::OFS_RES0 + 8'(4 * c), 32'hFF);
    end
    rd("irq masked", lst_pkg::OFS_IRQ_STAT, 32'h1);
    irq_chk(1'b0);
    wr(lst_pkg::OFS_IRQ_CLR, 32'h1);
    endt("default duration");
    // low-speed bus: good and bad checksums, packet and parity errors
    for (int k = 0; k < 4; k++) begin
      v = xrand();
      sum = (k % 2 == 0) ? lst_pkg::LS_GOOD_SUM : v[23:0];
      pkt = (k == 2);
      par = (k == 3);
      @(posedge clk);
      ls_test_start <= 1'b1;
      @(posedge clk);
      ls_test_start   <= 1'b0;
      ls_packet_error <= pkt;
      ls_parity_error <= par;
      @(posedge clk);
      ls_packet_error <= 1'b0;
      ls_parity_error <= 1'b0;
      ls_checksum     <= sum;
      ls_test_done    <= 1'b1;
      @(posedge clk);
      ls_test_done <= 1'b0;
      v = {sum, 5'h00, par, pkt, sum == lst_pkg::LS_GOOD_SUM};
      rd("ls result", lst_pkg::OFS_LSRES, v);
    end
    endt("low speed bus");
    array_unsupported <= 1'b1;
    repeat (3) @(posedge clk);
    rd("array flag", lst_pkg::OFS_ATYPE, 32'h1);
    array_unsupported <= 1'b0;
    repeat (3) @(posedge clk);
    rd("array clear", lst_pkg::OFS_ATYPE, 32'h0);
    rd("irq all", lst_pkg::OFS_IRQ_STAT, 32'hE);
    wr(lst_pkg::OFS_IRQ_EN, 32'hF);
    irq_chk(1'b1);
    endt("array and interrupts");
    repeat (4) @(posedge clk);
    check("pending notes", 32'(exp_q.size() + rx_q.size()), 32'h0);
    close_out();
  end
endmodule

`default_nettype wire
